/* rtl/timer0_core.sv */
// Overview of operation
// - rollover FFh to 00h sets overflow flag bit 2
// - clock select clear: count every instruction cycle
// - count write suppresses two instruction cycles
// - clock select set: count pin edges, edge bit
// - external edges synchronised before reaching counter
// - one prescaler, owned by timer or watchdog
// - assign clear: timer ratios 1:2 to 1:256
// - assign set: watchdog ratios 1:1 to 1:128
// - prescaler count hidden; option bits 3:0 control
// - count write clears prescaler when timer owns it
// - watchdog clear clears prescaler when watchdog owns
// - assignment may change at any time
// - overflow request gated by enable bit 5
// - hardware never clears flag; software clears it
// - timer halted in sleep, no overflow wake
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
module timer0_core (
	input wire logic MCLK,
	input wire logic RST,
	input wire timer0_pkg::apb_req_t APB_REQ,
	output timer0_pkg::apb_rsp_t APB_RSP,
	input wire logic EXT_COUNT_CLOCK_PIN,
	input wire logic SLEEP,
	input wire logic WDT_TICK,
	input wire logic WATCHDOG_CLEAR_INSTR,
	output logic WDT_TIMEOUT,
	output logic OVF_IRQ,
	output logic IRQ
);
	import timer0_pkg::*;

	// the whole state of the block
	typedef struct packed {
		logic [1:0] div; // instruction cycle divider
		logic [7:0] tick_count; // the visible count
		logic [7:0] irq_control; // interrupt control byte
		logic [7:0] option_config; // source, edge, assignment, ratio
		logic [5:0] port_a_dir; // plain storage, no effect here
		logic [7:0] pre; // shared prescaler, not software visible
		logic [1:0] inhibit; // instruction cycles left to suppress
		logic [2:0] sync; // pin synchroniser chain
		logic ext_lvl; // debounced pin level
		logic [EVT_W-1:0] evt_status; // sticky event bits
		logic [EVT_W-1:0] evt_enable; // event enables
		logic [DATA_W-1:0] prdata; // read data held for access phase
		logic wdt_out; // postscaled watchdog pulse
	} state_t;

	// reset image of the state
	localparam state_t RST_VAL = '{
		div: 2'h0,
		tick_count: RST_TICK_COUNT,
		irq_control: RST_IRQ_CONTROL,
		option_config: RST_OPTION_CONFIG,
		port_a_dir: RST_PORT_A_DIR,
		pre: 8'h00,
		inhibit: 2'h0,
		sync: 3'h0,
		ext_lvl: 1'b0,
		evt_status: '0,
		evt_enable: '0,
		prdata: 32'h0000_0000,
		wdt_out: 1'b0
	};

	state_t r; // registered state
	state_t n; // next state

	logic instr_en; // one pulse per instruction cycle
	logic agree; // second and third sync stages agree
	logic lvl_chg; // settled pin level differs from last
	logic rise; // settled rising edge
	logic fall; // settled falling edge
	logic clk_sel; // clock source select
	logic edge_sel; // falling edge when set
	logic assign_wdt; // prescaler owned by watchdog
	logic [2:0] ratio; // ratio select code
	logic [7:0] tmr_mask; // timer match mask
	logic [7:0] wdt_mask; // watchdog match mask
	logic src_evt; // raw counting event
	logic timer_evt; // counting event after gating
	logic tmr_inc; // increment the count this cycle
	logic wdt_pulse; // postscaled watchdog event
	logic ovf; // count rolls over this cycle
	logic ovf_set; // rollover that survives a write
	logic setup; // apb setup phase
	logic access; // apb access phase
	logic hit; // address is mapped
	logic wr; // accepted write
	logic [7:0] wbyte; // low byte of write data
	logic [DATA_W-1:0] rd_mux; // read data selection

	// option field decode
	always_comb begin
		clk_sel = r.option_config[OPT_CLK_SRC];
		edge_sel = r.option_config[OPT_EDGE];
		assign_wdt = r.option_config[OPT_ASSIGN];
		ratio = r.option_config[OPT_RATIO_LSB +: 3];
	end

	// address decode; unmapped addresses answer with an error
	always_comb begin
		unique case (APB_REQ.paddr)
			ADDR_TICK_COUNT,
			ADDR_IRQ_CONTROL,
			ADDR_OPTION_CONFIG,
			ADDR_PORT_A_DIR,
			ADDR_EVT_STATUS,
			ADDR_EVT_CLEAR,
			ADDR_EVT_ENABLE: begin
				hit = 1'b1;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	// read mux; the clear register reads as zero, prescaler never appears
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (APB_REQ.paddr)
			ADDR_TICK_COUNT: begin
				rd_mux[7:0] = r.tick_count;
			end
			ADDR_IRQ_CONTROL: begin
				rd_mux[7:0] = r.irq_control;
			end
			ADDR_OPTION_CONFIG: begin
				rd_mux[7:0] = r.option_config;
			end
			ADDR_PORT_A_DIR: begin
				rd_mux[5:0] = r.port_a_dir;
			end
			ADDR_EVT_STATUS: begin
				rd_mux[EVT_W-1:0] = r.evt_status;
			end
			ADDR_EVT_ENABLE: begin
				rd_mux[EVT_W-1:0] = r.evt_enable;
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	// next state
	always_comb begin
		n = r;
		// instruction cycle enable from the oscillator divider
		instr_en = (r.div == DIV_LAST);
		n.div = 2'(r.div + 2'h1);

		// three-stage pin synchroniser; only stages two and three are compared
		n.sync = {r.sync[1:0], EXT_COUNT_CLOCK_PIN};
		agree = (r.sync[1] == r.sync[2]);
		lvl_chg = agree && (r.sync[2] != r.ext_lvl);
		if (agree) begin
			n.ext_lvl = r.sync[2];
		end
		rise = lvl_chg && r.sync[2];
		fall = lvl_chg && !r.sync[2];

		// source select: instruction cycles or chosen pin edge
		if (clk_sel) begin
			src_evt = edge_sel ? fall : rise;
		end else begin
			src_evt = instr_en;
		end

		// sleep stops counting, so no overflow can arise to wake the core
		timer_evt = src_evt && !SLEEP && (r.inhibit == 2'h0);
		if (instr_en && (r.inhibit != 2'h0)) begin
			n.inhibit = 2'(r.inhibit - 2'h1);
		end

		// ratio masks: code 000 is the smallest ratio, each step doubles
		tmr_mask = ~(TMR_MASK_SEED << ratio);
		wdt_mask = ~(WDT_MASK_SEED << ratio);

		// one prescaler; whoever does not own it runs undivided
		tmr_inc = 1'b0;
		wdt_pulse = 1'b0;
		if (!assign_wdt) begin
			wdt_pulse = WDT_TICK;
			if (timer_evt) begin
				if ((r.pre & tmr_mask) == tmr_mask) begin
					n.pre = 8'h00;
					tmr_inc = 1'b1;
				end else begin
					n.pre = 8'(r.pre + 8'h01);
				end
			end
		end else begin
			tmr_inc = timer_evt;
			if (WATCHDOG_CLEAR_INSTR) begin
				n.pre = 8'h00;
			end else if (WDT_TICK) begin
				if ((r.pre & wdt_mask) == wdt_mask) begin
					n.pre = 8'h00;
					wdt_pulse = 1'b1;
				end else begin
					n.pre = 8'(r.pre + 8'h01);
				end
			end
		end
		n.wdt_out = wdt_pulse;

		// counter and rollover detect
		ovf = tmr_inc && (r.tick_count == MAX_COUNT);
		if (tmr_inc) begin
			n.tick_count = 8'(r.tick_count + 8'h01);
		end

		// apb phases; write takes effect at the access edge only
		setup = APB_REQ.psel && !APB_REQ.penable;
		access = APB_REQ.psel && APB_REQ.penable;
		wr = access && APB_REQ.pwrite && hit;
		wbyte = APB_REQ.pwdata[7:0];
		ovf_set = ovf;

		// count write wins over an increment in the same cycle
		if (wr && (APB_REQ.paddr == ADDR_TICK_COUNT)) begin
			n.tick_count = wbyte;
			n.inhibit = INHIBIT_CYC;
			ovf_set = 1'b0;
			if (!assign_wdt) begin
				n.pre = 8'h00;
			end
		end

		// option writes may move the prescaler at any time
		if (wr && (APB_REQ.paddr == ADDR_OPTION_CONFIG)) begin
			n.option_config = wbyte;
		end

		if (wr && (APB_REQ.paddr == ADDR_PORT_A_DIR)) begin
			n.port_a_dir = wbyte[5:0];
		end

		// flag only falls by software write; a rollover in the same cycle wins
		if (wr && (APB_REQ.paddr == ADDR_IRQ_CONTROL)) begin
			n.irq_control = wbyte;
		end
		if (ovf_set) begin
			n.irq_control[IRQC_OVF_FLAG] = 1'b1;
		end

		// sticky events: set beats a simultaneous clear
		if (wr && (APB_REQ.paddr == ADDR_EVT_CLEAR)) begin
			n.evt_status = r.evt_status & ~APB_REQ.pwdata[EVT_W-1:0];
		end
		n.evt_status[EVT_OVF] = n.evt_status[EVT_OVF] | ovf_set;
		n.evt_status[EVT_WDT] = n.evt_status[EVT_WDT] | wdt_pulse;

		if (wr && (APB_REQ.paddr == ADDR_EVT_ENABLE)) begin
			n.evt_enable = APB_REQ.pwdata[EVT_W-1:0];
		end

		// read data captured in setup so it is a flop in the access phase
		if (setup) begin
			n.prdata = rd_mux;
		end
	end

	// the only clocked process
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			r <= RST_VAL;
		end else begin
			r <= n;
		end
	end

	// outputs; zero wait states, error only on unmapped access
	always_comb begin
		APB_RSP.pready = 1'b1;
		APB_RSP.pslverr = access && !hit;
		APB_RSP.prdata = r.prdata;
		WDT_TIMEOUT = r.wdt_out;
		OVF_IRQ = r.irq_control[IRQC_OVF_EN] && r.irq_control[IRQC_OVF_FLAG];
		IRQ = |(r.evt_status & r.evt_enable);
	end

endmodule : timer0_core

/* rtl/timer0_pkg.sv */
package timer0_pkg;

	// bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// register indices as printed; byte address is four times the index
	localparam int IDX_TICK_COUNT = 'h01;
	localparam int IDX_IRQ_CONTROL = 'h0B;
	localparam int IDX_OPTION_CONFIG = 'h81;
	localparam int IDX_PORT_A_DIR = 'h85;
	localparam int IDX_EVT_STATUS = 'h90;
	localparam int IDX_EVT_CLEAR = 'h91;
	localparam int IDX_EVT_ENABLE = 'h92;

	localparam logic [ADDR_W-1:0] ADDR_TICK_COUNT = 12'(IDX_TICK_COUNT * 4);
	localparam logic [ADDR_W-1:0] ADDR_IRQ_CONTROL = 12'(IDX_IRQ_CONTROL * 4);
	localparam logic [ADDR_W-1:0] ADDR_OPTION_CONFIG = 12'(IDX_OPTION_CONFIG * 4);
	localparam logic [ADDR_W-1:0] ADDR_PORT_A_DIR = 12'(IDX_PORT_A_DIR * 4);
	localparam logic [ADDR_W-1:0] ADDR_EVT_STATUS = 12'(IDX_EVT_STATUS * 4);
	localparam logic [ADDR_W-1:0] ADDR_EVT_CLEAR = 12'(IDX_EVT_CLEAR * 4);
	localparam logic [ADDR_W-1:0] ADDR_EVT_ENABLE = 12'(IDX_EVT_ENABLE * 4);

	// field positions in the option register
	localparam int OPT_CLK_SRC = 5;
	localparam int OPT_EDGE = 4;
	localparam int OPT_ASSIGN = 3;
	localparam int OPT_RATIO_LSB = 0;

	// field positions in the interrupt control register
	localparam int IRQC_OVF_EN = 5;
	localparam int IRQC_OVF_FLAG = 2;

	// event status bit positions
	localparam int EVT_OVF = 0;
	localparam int EVT_WDT = 1;
	localparam int EVT_W = 2;

	// values after reset
	localparam logic [7:0] RST_TICK_COUNT = 8'h00;
	localparam logic [7:0] RST_IRQ_CONTROL = 8'h00;
	localparam logic [7:0] RST_OPTION_CONFIG = 8'hFF;
	localparam logic [5:0] RST_PORT_A_DIR = 6'h3F;

	// timing: one instruction cycle is four oscillator periods
	localparam int OSC_PER_INSTR = 4;
	localparam logic [1:0] DIV_LAST = 2'(OSC_PER_INSTR - 1);
	localparam logic [1:0] INHIBIT_CYC = 2'h2;

	// prescaler mask seeds (timer starts at 1:2, watchdog at 1:1)
	localparam logic [7:0] TMR_MASK_SEED = 8'hFE;
	localparam logic [7:0] WDT_MASK_SEED = 8'hFF;
	localparam logic [7:0] MAX_COUNT = 8'hFF;

	// apb request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} apb_req_t;

	// apb answer to the master
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [DATA_W-1:0] prdata;
	} apb_rsp_t;

endpackage : timer0_pkg

/* testbench/ext_clk_src.sv */
`timescale 1ns/10ps
module ext_clk_src (
	input wire logic mclk,
	output logic pin
);
	// source idles low until the bench asks for edges
	initial pin = 1'b0;
	// each toggle is one edge; long levels let the synchroniser settle
	task automatic toggle(input int n);
		repeat (n) begin
			repeat (6) @(posedge mclk);
			pin <= ~pin;
		end
		repeat (8) @(posedge mclk);
	endtask : toggle
endmodule : ext_clk_src

/* testbench/timer0_chk.sv */
`timescale 1ns/10ps
module timer0_chk
	import timer0_pkg::*;
(
	input wire logic MCLK,
	input wire logic RST,
	input wire timer0_pkg::apb_req_t APB_REQ,
	input wire timer0_pkg::apb_rsp_t APB_RSP,
	input wire logic SLEEP,
	input wire logic WDT_TICK,
	input wire logic WDT_TIMEOUT,
	input wire logic OVF_IRQ,
	input wire logic IRQ
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (RST);
	// access phase of any transfer
	sequence acc_s;
		APB_REQ.psel && APB_REQ.penable;
	endsequence
	a_ready_high: assert property (APB_RSP.pready) else $error("pready low");
	a_err_scope: assert property (APB_RSP.pslverr |-> acc_s) else $error("stray pslverr");
	a_err_hole: assert property (acc_s ##0 (APB_REQ.paddr == 12'h000) |-> APB_RSP.pslverr)
		else $error("unmapped access not refused");
	a_err_mapped: assert property (acc_s ##0 (APB_REQ.paddr == ADDR_TICK_COUNT) |-> !APB_RSP.pslverr)
		else $error("mapped access refused");
	// read data must stand after the access phase
	a_rdata_hold: assert property (acc_s ##0 !APB_REQ.pwrite |=> $stable(APB_RSP.prdata))
		else $error("read data moved");
	// a rise needs a count edge out of sleep, or a register write
	// the flag or the enable lands at the edge before the rise is seen
	a_sleep_quiet: assert property ($rose(OVF_IRQ) |-> !$past(SLEEP) || $past(APB_REQ.penable))
		else $error("overflow while asleep");
	// only software may drop the flag
	a_flag_sticky: assert property ($fell(OVF_IRQ) |-> $past(APB_REQ.pwrite && APB_REQ.penable))
		else $error("overflow request dropped by itself");
	a_irq_sticky: assert property ($fell(IRQ) |-> $past(APB_REQ.pwrite && APB_REQ.penable))
		else $error("irq dropped by itself");
	a_wdt_cause: assert property (WDT_TIMEOUT |-> $past(WDT_TICK))
		else $error("timeout without tick");
endmodule : timer0_chk

/* testbench/timer0_with_shared_prescaler_test.sv */
`timescale 1ns/10ps
module timer0_with_shared_prescaler_test;
	import timer0_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	apb_req_t req = '0;
	apb_rsp_t rsp;
	logic pin, wto, ovf, irq;
	logic sleep = 1'b0;
	logic tick = 1'b0;
	logic wclr = 1'b0;
	int mismatches = 0;
	int samples_checked = 0;
	int tmo = 0; // watchdog timeouts seen
	int c;
	logic [31:0] rd, b;
	always #5 mclk = ~mclk;
	timer0_core i_dut (.MCLK(mclk), .RST(rst), .APB_REQ(req), .APB_RSP(rsp),
		.EXT_COUNT_CLOCK_PIN(pin), .SLEEP(sleep), .WDT_TICK(tick),
		.WATCHDOG_CLEAR_INSTR(wclr), .WDT_TIMEOUT(wto), .OVF_IRQ(ovf), .IRQ(irq));
	ext_clk_src i_src (.mclk(mclk), .pin(pin));
	// timeout pulses last one cycle, so count them as they pass
	always @(posedge mclk) if (wto === 1'b1) tmo <= tmo + 1;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// one apb transfer; an idle edge after it keeps psel from toggling twice
	task automatic xfer(input logic [11:0] ad, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		req <= '{1'b1, 1'b0, w, ad, d};
		@(posedge mclk);
		req.penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		rd = rsp.prdata;
		req <= '0;
		@(posedge mclk);
	endtask : xfer
	task automatic rchk(input logic [11:0] ad, input logic [31:0] e);
		xfer(ad, 1'b0, '0);
		check(rd, e);
	endtask : rchk
	// levels are read mid-cycle, after the edge has landed
	task automatic lchk(input logic s, input logic e);
		@(negedge mclk);
		check(s ? irq : ovf, e);
		@(posedge mclk);
	endtask : lchk
	// one watchdog tick (s=1) or clear instruction (s=0)
	task automatic pulse(input logic s);
		if (s) tick <= 1'b1;
		else wclr <= 1'b1;
		@(posedge mclk);
		tick <= 1'b0;
		wclr <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask : pulse
	task automatic final_report;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report
	initial begin
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		rchk(ADDR_OPTION_CONFIG, 32'h0000_00FF);
		rchk(ADDR_PORT_A_DIR, 32'h0000_003F);
		rchk(ADDR_IRQ_CONTROL, 32'h0000_0000);
		rchk(12'h000, 32'h0000_0000);
		$display("reset test done");
		// count gained over whole prescaler periods, each ratio code
		for (int i = 0; i < 9; i++) begin
			xfer(ADDR_OPTION_CONFIG, 1'b1, (i == 0) ? 32'h0000_0008 : 32'(i - 1));
			xfer(ADDR_TICK_COUNT, 1'b1, '0);
			repeat (12) @(posedge mclk);
			xfer(ADDR_TICK_COUNT, 1'b0, '0);
			b = rd;
			repeat ((40 << ((i == 0) ? 0 : i - 1)) - 3) @(posedge mclk);
			rchk(ADDR_TICK_COUNT, b + ((i == 0) ? 10 : 5));
		end
		// twelve edges hold three pulses, two of them swallowed
		// moving the prescaler to the watchdog: clear first, then switch
		pulse(1'b0);
		xfer(ADDR_OPTION_CONFIG, 1'b1, 32'h0000_0008);
		xfer(ADDR_TICK_COUNT, 1'b1, 32'h0000_0010);
		repeat (11) @(posedge mclk);
		rchk(ADDR_TICK_COUNT, 32'h0000_0011);
		$display("rate test done");
		xfer(ADDR_IRQ_CONTROL, 1'b1, 32'h0000_0020);
		xfer(ADDR_TICK_COUNT, 1'b1, 32'h0000_00FF);
		repeat (14) @(posedge mclk);
		rchk(ADDR_IRQ_CONTROL, 32'h0000_0024);
		rchk(ADDR_EVT_STATUS, 32'h0000_0001);
		lchk(1'b0, 1'b1);
		xfer(ADDR_IRQ_CONTROL, 1'b1, 32'h0000_0004);
		lchk(1'b0, 1'b0);
		xfer(ADDR_EVT_ENABLE, 1'b1, 32'h0000_0001);
		lchk(1'b1, 1'b1);
		xfer(ADDR_EVT_STATUS, 1'b1, '0);
		rchk(ADDR_EVT_STATUS, 32'h0000_0001);
		xfer(ADDR_EVT_CLEAR, 1'b1, 32'h0000_0001);
		lchk(1'b1, 1'b0);
		rchk(ADDR_IRQ_CONTROL, 32'h0000_0004);
		xfer(ADDR_IRQ_CONTROL, 1'b1, '0);
		$display("irq test done");
		sleep <= 1'b1;
		xfer(ADDR_TICK_COUNT, 1'b0, '0);
		b = rd;
		repeat (40) @(posedge mclk);
		rchk(ADDR_TICK_COUNT, b);
		sleep <= 1'b0;
		// five edges from low give three rising; from high three falling
		for (int e = 0; e < 2; e++) begin
			xfer(ADDR_OPTION_CONFIG, 1'b1, e ? 32'h0000_0038 : 32'h0000_0028);
			xfer(ADDR_TICK_COUNT, 1'b1, '0);
			repeat (12) @(posedge mclk);
			i_src.toggle(5);
			rchk(ADDR_TICK_COUNT, 32'h0000_0003);
		end
		$display("counter test done");
		for (int r = 0; r < 8; r++) begin
			xfer(ADDR_OPTION_CONFIG, 1'b1, 32'(8 + r));
			pulse(1'b0);
			c = tmo;
			repeat (2 << r) pulse(1'b1);
			check(tmo - c, 2);
		end
		// clear between two ticks at 1:2 leaves no timeout
		pulse(1'b0);
		c = tmo;
		pulse(1'b1);
		xfer(ADDR_OPTION_CONFIG, 1'b1, 32'h0000_0009);
		pulse(1'b0);
		c = tmo;
		pulse(1'b1);
		pulse(1'b0);
		pulse(1'b1);
		check(tmo - c, 0);
		xfer(ADDR_OPTION_CONFIG, 1'b1, '0);
		c = tmo;
		pulse(1'b1);
		pulse(1'b1);
		check(tmo - c, 2);
		$display("watchdog test done");
		final_report();
	end
	// the whole run needs about 12800 cycles
	initial begin
		repeat (40000) @(posedge mclk);
		mismatches++;
		final_report();
	end
endmodule : timer0_with_shared_prescaler_test
bind timer0_core timer0_chk chk (.MCLK(MCLK), .RST(RST), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP),
	.SLEEP(SLEEP), .WDT_TICK(WDT_TICK), .WDT_TIMEOUT(WDT_TIMEOUT), .OVF_IRQ(OVF_IRQ), .IRQ(IRQ));
